// ### logic/smpc_sleep_ctrl.sv
// Sleep mode power controller: control register over AHB-Lite, sleep entry, clock gates, wake sequencing.
// Assumes the core pulses i_sleep_exec on SLEEP and honours o_cpu_stall; wake sources arrive asynchronously.
`timescale 1ns/1ps
`include "smpc_cfg.svh"
module smpc_sleep_ctrl import smpc_pkg::*; #(
  parameter int unsigned DLY_SHORT_CYC = (`SMPC_DLY_SHORT_NS + `SMPC_CLK_NS - 1) / `SMPC_CLK_NS,
  parameter int unsigned DLY_LONG_CYC = (`SMPC_DLY_LONG_NS + `SMPC_CLK_NS - 1) / `SMPC_CLK_NS
) (
  // Clock, reset, enable
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Fuses
  input wire logic [3:0] i_clock_source_select_fuses,
  input wire logic [1:0] i_startup_time_fuses,
  // Core side
  input wire logic i_sleep_exec,
  input wire logic i_adc_enabled,
  input wire logic i_timer2_async_select,
  output logic o_cpu_stall,
  output logic o_wake_irq,
  output logic o_wake_reset,
  output logic o_adc_start,
  // Wake sources, asynchronous
  input wire logic i_irq_any,
  input wire logic i_irq_adc,
  input wire logic i_irq_level_ext,
  input wire logic i_irq_twi_match,
  input wire logic i_irq_timer2,
  input wire logic i_irq_spm_ready,
  input wire logic i_reset_req,
  // Clock gates, high means running; o_ext_clk_sel high selects the external clock
  output logic o_clk_cpu_en,
  output logic o_clk_flash_en,
  output logic o_clk_io_en,
  output logic o_clk_adc_en,
  output logic o_clk_async_en,
  output logic o_osc_en,
  output logic o_ext_clk_sel
);
  localparam int unsigned WAKE_CYC = `SMPC_WAKE_CK;
  localparam int unsigned HALT_CYC = `SMPC_HALT_CK;
  localparam int unsigned CW = 24;

  // ==========================================================
  // Wake source synchronisers
  logic [6:0] async_in;
  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  assign async_in = {i_reset_req, i_irq_spm_ready, i_irq_timer2, i_irq_twi_match, i_irq_level_ext, i_irq_adc, i_irq_any};
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_reg <= 7'h00;
      sync2_reg <= 7'h00;
    end else if (i_clk_en) begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end
  logic w_any, w_adc, w_lvl, w_twi, w_t2, w_spm, w_rst;
  assign {w_rst, w_spm, w_t2, w_twi, w_lvl, w_adc, w_any} = sync2_reg;

  // ==========================================================
  // AHB-Lite slave and control register
  logic [7:0] ctrl_reg;
  logic wr_pend_reg;
  logic [3:0] addr_reg;
  logic [31:0] rdata_next;
  smpc_state_e state_reg;
  smpc_mode_e mode_reg;
  logic take;
  assign take = i_hsel && i_hready && i_htrans[1];
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 4'h0;
    end else if (i_clk_en) begin
      wr_pend_reg <= take && i_hwrite;
      if (take) begin
        addr_reg <= i_haddr[3:0];
      end
    end
  end
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_reg <= `SMPC_CTRL_RESET;
    end else if (i_clk_en && wr_pend_reg && addr_reg == `SMPC_ADDR_CTRL) begin
      ctrl_reg <= i_hwdata[7:0];
    end
  end
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (take && !i_hwrite) begin
      unique case (i_haddr[3:0])
        `SMPC_ADDR_CTRL: rdata_next = {24'h00_0000, ctrl_reg};
        `SMPC_ADDR_STAT: rdata_next = {21'h00_0000, mode_reg, 5'h00, state_reg};
        `SMPC_ADDR_FUSE: rdata_next = {26'h000_0000, i_startup_time_fuses, i_clock_source_select_fuses};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end
  // Zero wait states: read data registered at the address-phase edge
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_hrdata <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else if (i_clk_en) begin
      o_hrdata <= rdata_next;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
  end

  // ==========================================================
  // Sleep sequencer
  logic ext_clk;
  logic xtal_clk;
  logic [CW-1:0] cnt_reg;
  logic wake_ok;
  logic mode_legal;
  logic [CW-1:0] rst_dly;
  assign ext_clk = i_clock_source_select_fuses == `SMPC_CLOCK_SOURCE_SELECT_FUSES_EXT;
  assign xtal_clk = i_clock_source_select_fuses >= `SMPC_CLOCK_SOURCE_SELECT_FUSES_XTAL_MIN;
  // Reserved fuse code 11 treated as no extra delay
  always_comb begin
    unique case (i_startup_time_fuses)
      2'b01: rst_dly = CW'(DLY_SHORT_CYC);
      2'b10: rst_dly = CW'(DLY_LONG_CYC);
      default: rst_dly = CW'(1);
    endcase
  end
  // Reserved codes and standby without crystal do not sleep
  always_comb begin
    unique case (ctrl_reg[`SMPC_MODE_HI:`SMPC_MODE_LO])
      3'h0, 3'h1, 3'h2, 3'h3: mode_legal = 1'b1;
      3'h6: mode_legal = xtal_clk;
      default: mode_legal = 1'b0;
    endcase
  end
  always_comb begin
    unique case (mode_reg)
      SMPC_IDLE: wake_ok = w_any;
      SMPC_NOISE: wake_ok = w_adc | w_lvl | w_twi | w_t2 | w_spm;
      SMPC_SAVE: wake_ok = w_lvl | w_twi | (w_t2 & i_timer2_async_select);
      default: wake_ok = w_lvl | w_twi;
    endcase
  end
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= SMPC_RUN;
      mode_reg <= SMPC_IDLE;
      cnt_reg <= '0;
      o_wake_irq <= 1'b0;
      o_wake_reset <= 1'b0;
      o_adc_start <= 1'b0;
    end else if (i_clk_en) begin
      o_wake_irq <= 1'b0;
      o_wake_reset <= 1'b0;
      o_adc_start <= 1'b0;
      unique case (state_reg)
        SMPC_RUN: begin
          // Arm bit clear: SLEEP passes as a no-op
          if (i_sleep_exec && ctrl_reg[`SMPC_BIT_ARM] && mode_legal) begin
            state_reg <= SMPC_SLEEP;
            mode_reg <= smpc_mode_e'(ctrl_reg[`SMPC_MODE_HI:`SMPC_MODE_LO]);
            o_adc_start <= i_adc_enabled && !ctrl_reg[`SMPC_MODE_HI + 1 - 2];
          end
        end
        SMPC_SLEEP: begin
          if (w_rst) begin
            state_reg <= SMPC_RESET_DLY;
            cnt_reg <= rst_dly;
          end else if (wake_ok) begin
            state_reg <= SMPC_START;
            // Clocked idle and noise modes need no oscillator restart
            cnt_reg <= (mode_reg == SMPC_IDLE || mode_reg == SMPC_NOISE) ? CW'(1) : CW'(WAKE_CYC);
          end
        end
        SMPC_START: begin
          if (cnt_reg <= CW'(1)) begin
            state_reg <= SMPC_HALT;
            cnt_reg <= CW'(HALT_CYC);
          end else begin
            cnt_reg <= cnt_reg - CW'(1);
          end
        end
        SMPC_HALT: begin
          if (cnt_reg <= CW'(1)) begin
            state_reg <= SMPC_RUN;
            o_wake_irq <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - CW'(1);
          end
        end
        SMPC_RESET_DLY: begin
          if (cnt_reg <= CW'(1)) begin
            state_reg <= SMPC_RUN;
            o_wake_reset <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - CW'(1);
          end
        end
        default: state_reg <= SMPC_RUN;
      endcase
    end
  end

  // ==========================================================
  // Clock gates; no SRAM or register file clock is ever reset here
  logic asleep;
  assign asleep = state_reg == SMPC_SLEEP;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cpu_stall <= 1'b0;
      o_clk_cpu_en <= 1'b1;
      o_clk_flash_en <= 1'b1;
      o_clk_io_en <= 1'b1;
      o_clk_adc_en <= 1'b1;
      o_clk_async_en <= 1'b1;
      o_osc_en <= 1'b1;
      o_ext_clk_sel <= 1'b0;
    end else if (i_clk_en) begin
      o_ext_clk_sel <= ext_clk;
      o_cpu_stall <= state_reg != SMPC_RUN;
      o_clk_cpu_en <= !asleep;
      o_clk_flash_en <= !asleep;
      o_clk_io_en <= !(asleep && mode_reg != SMPC_IDLE);
      o_clk_adc_en <= !(asleep && mode_reg > SMPC_NOISE);
      o_clk_async_en <= !(asleep && mode_reg > SMPC_NOISE && !(mode_reg == SMPC_SAVE && i_timer2_async_select));
      o_osc_en <= !(asleep && mode_reg > SMPC_NOISE && mode_reg != SMPC_STANDBY);
    end
  end

  // ==========================================================
  // Checks
  AST_NO_ARM_NO_SLEEP: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_clk_en && state_reg == SMPC_RUN && i_sleep_exec && !ctrl_reg[7]) |=> state_reg == SMPC_RUN)
    else $error("sleep entered with arm bit clear");
  AST_RESET_ZERO: assert property (@(posedge i_clock) $rose(i_nrst) |-> ctrl_reg == 8'h00)
    else $error("control register not zero after reset");
  AST_IDLE_IO_RUNS: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_clk_en && asleep && mode_reg == SMPC_IDLE) |=> o_clk_io_en && !o_clk_cpu_en)
    else $error("idle gating wrong");
  AST_NOISE_IO_STOP: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_clk_en && asleep && mode_reg == SMPC_NOISE) |=> !o_clk_io_en && o_clk_adc_en)
    else $error("noise mode gating wrong");
  AST_DOWN_ALL_STOP: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_clk_en && asleep && mode_reg == SMPC_DOWN) |=> !o_clk_adc_en && !o_osc_en && !o_clk_async_en)
    else $error("power-down gating wrong");
  AST_STANDBY_OSC: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_clk_en && asleep && mode_reg == SMPC_STANDBY) |=> o_osc_en)
    else $error("standby oscillator stopped");
  AST_HALT_FOUR: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_clk_en)
    $rose(state_reg == SMPC_HALT) |-> (state_reg == SMPC_HALT) [*4] ##1 o_wake_irq)
    else $error("halt not four cycles");
  AST_RESET_WAKE: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_clk_en && asleep && w_rst) |=> state_reg == SMPC_RESET_DLY)
    else $error("reset during sleep ignored");
  AST_STANDBY_XTAL: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_clk_en && state_reg == SMPC_RUN && i_sleep_exec && ctrl_reg[6:4] == 3'h6 && !xtal_clk) |=> state_reg == SMPC_RUN)
    else $error("standby without crystal");

  // Bus side and control register
  AST_BUS_OKAY: assert property (@(posedge i_clock) disable iff (!i_nrst)
    o_hreadyout && !o_hresp)
    else $error("bus answer not ready or not okay");
  AST_CTRL_WRITE: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_clk_en && wr_pend_reg && addr_reg == `SMPC_ADDR_CTRL) |=> ctrl_reg == $past(i_hwdata[7:0]))
    else $error("control write lost");
  AST_CTRL_HOLD: assert property (@(posedge i_clock) disable iff (!i_nrst)
    !(i_clk_en && wr_pend_reg && addr_reg == `SMPC_ADDR_CTRL) |=> $stable(ctrl_reg))
    else $error("control register changed without a write");
  AST_READ_CTRL: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_clk_en && take && !i_hwrite && i_haddr[3:0] == `SMPC_ADDR_CTRL) |=> o_hrdata == {24'h00_0000, $past(ctrl_reg)})
    else $error("control read data wrong");
  AST_EXT_SEL: assert property (@(posedge i_clock) disable iff (!i_nrst)
    i_clk_en |=> o_ext_clk_sel == ($past(i_clock_source_select_fuses) == `SMPC_CLOCK_SOURCE_SELECT_FUSES_EXT))
    else $error("external clock select wrong");

  // Sleep entry
  AST_SLEEP_ENTRY: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_clk_en && state_reg == SMPC_RUN && i_sleep_exec && ctrl_reg[7] && mode_legal) |=> state_reg == SMPC_SLEEP)
    else $error("armed sleep not entered");
  AST_RESERVED_MODE: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_clk_en && state_reg == SMPC_RUN && ctrl_reg[6:5] == 2'b10) |=> state_reg == SMPC_RUN)
    else $error("reserved mode slept");
  AST_MODE_LATCH: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (state_reg == SMPC_RUN) ##1 (state_reg == SMPC_SLEEP) |-> mode_reg == $past(ctrl_reg[6:4]))
    else $error("latched mode differs from field");
  AST_NOP_RUNS: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_clk_en && state_reg == SMPC_RUN) |=> o_clk_cpu_en && o_clk_flash_en)
    else $error("clock gated while running");
  AST_ADC_START: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_clk_en && state_reg == SMPC_RUN && i_sleep_exec && ctrl_reg[7] && mode_legal && i_adc_enabled
      && ctrl_reg[6:5] == 2'b00) |=> o_adc_start)
    else $error("conversion not started on entry");

  // Gates and stall
  AST_STALL_SET: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_clk_en && state_reg != SMPC_RUN) |=> o_cpu_stall)
    else $error("core not stalled");
  AST_STALL_CLR: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_clk_en && state_reg == SMPC_RUN) |=> !o_cpu_stall)
    else $error("core stalled while running");
  AST_SAVE_ASYNC: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_clk_en && asleep && mode_reg == SMPC_SAVE && i_timer2_async_select) |=> o_clk_async_en && !o_osc_en)
    else $error("power-save async clock wrong");
  AST_STANDBY_GATES: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_clk_en && asleep && mode_reg == SMPC_STANDBY) |=> !o_clk_adc_en && !o_clk_io_en)
    else $error("standby gating wrong");

  // Wake masks and timing
  AST_WAKE_START: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_clk_en && asleep && !w_rst && wake_ok) |=> state_reg == SMPC_START)
    else $error("enabled wake ignored");
  AST_NOISE_MASK: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_clk_en && asleep && mode_reg == SMPC_NOISE && !w_rst && !w_adc && !w_lvl && !w_twi && !w_t2 && !w_spm)
      |=> asleep)
    else $error("noise mode woke on a masked source");
  AST_DOWN_MASK: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_clk_en && asleep && mode_reg == SMPC_DOWN && !w_rst && !w_lvl && !w_twi) |=> asleep)
    else $error("power-down woke on a masked source");
  AST_START_LONG: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_clk_en)
    (asleep && !w_rst && wake_ok && mode_reg > SMPC_NOISE) |=> (state_reg == SMPC_START) [*6] ##1
      state_reg == SMPC_HALT)
    else $error("oscillator start not six cycles");
  AST_START_SHORT: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_clk_en)
    (asleep && !w_rst && wake_ok && mode_reg <= SMPC_NOISE) |=> state_reg == SMPC_START ##1
      state_reg == SMPC_HALT)
    else $error("clocked mode start not one cycle");
  AST_WAKE_PULSE: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_clk_en)
    o_wake_irq |=> !o_wake_irq)
    else $error("wake pulse longer than one cycle");
  AST_RESET_DONE: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_clk_en && state_reg == SMPC_RESET_DLY && cnt_reg <= CW'(1)) |=> o_wake_reset && state_reg == SMPC_RUN)
    else $error("reset wake not finished");
endmodule // smpc_sleep_ctrl

// ### pkg/smpc_cfg.svh
// Constants of the sleep mode power controller: register map, fields, fuse codes, timing.
// Assumes inclusion by bare name from the package and the design module.
`ifndef SMPC_CFG_SVH
`define SMPC_CFG_SVH
`define SMPC_ADDR_CTRL 4'h0
`define SMPC_ADDR_STAT 4'h4
`define SMPC_ADDR_FUSE 4'h8
`define SMPC_CTRL_RESET 8'h00
`define SMPC_BIT_ARM 7
`define SMPC_MODE_HI 6
`define SMPC_MODE_LO 4
`define SMPC_CLOCK_SOURCE_SELECT_FUSES_EXT 4'h0
`define SMPC_CLOCK_SOURCE_SELECT_FUSES_XTAL_MIN 4'hA
`define SMPC_WAKE_CK 6
`define SMPC_HALT_CK 4
`define SMPC_CLK_MHZ 200
`define SMPC_DLY_SHORT_NS 4100000
`define SMPC_DLY_LONG_NS 65000000
`define SMPC_CLK_NS 5
`endif

// ### pkg/smpc_pkg.sv
// Types of the sleep mode power controller.
// Assumes the config header sits beside it.
`include "smpc_cfg.svh"
package smpc_pkg;
  typedef enum logic [2:0] {
    SMPC_IDLE = 3'h0,
    SMPC_NOISE = 3'h1,
    SMPC_DOWN = 3'h2,
    SMPC_SAVE = 3'h3,
    SMPC_STANDBY = 3'h6
  } smpc_mode_e;
  typedef enum logic [2:0] {
    SMPC_RUN = 3'b000,
    SMPC_SLEEP = 3'b001,
    SMPC_START = 3'b011,
    SMPC_HALT = 3'b010,
    SMPC_RESET_DLY = 3'b110
  } smpc_state_e;
endpackage

// ### verif/smpc_core_model.sv
// Core model: issues SLEEP on request and counts how each wake ends.
// Assumes the bench raises i_go for one cycle while the core runs.
`timescale 1ns/1ps
module smpc_core_model (
  // Clock, reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Bench and controller side
  input wire logic i_go,
  input wire logic i_cpu_stall,
  input wire logic i_wake_irq,
  input wire logic i_wake_reset,
  output logic o_sleep_exec,
  output logic [7:0] o_resumes,
  output logic [7:0] o_restarts
);
  // =====================================
  // Instruction stream
  // A stalled core executes nothing, so no SLEEP while asleep
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sleep_exec <= 1'b0;
    end else begin
      o_sleep_exec <= i_go && !i_cpu_stall;
    end
  end
  // Handler plus return after SLEEP, or restart at the vector
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_resumes <= 8'h00;
      o_restarts <= 8'h00;
    end else begin
      if (i_wake_irq) o_resumes <= o_resumes + 8'h01;
      if (i_wake_reset) o_restarts <= o_restarts + 8'h01;
    end
  end
endmodule // smpc_core_model

// ### verif/tb_top.sv
// Bench for the sleep controller: registers, modes, gates, wake timing, refused SLEEP, reset wake.
// Assumes the package, config header and core model are compiled first.
`timescale 1ns/1ps
module tb_top;
  localparam int DS = 10;
  localparam int DL = 20;
  typedef struct packed {
    logic [2:0] m;
    logic [3:0] ck;
    logic as, adc;
    logic [5:0] s, g;
    logic [3:0] st;
  } smpc_row_s;
  logic i_clock, i_nrst, hsel, hwrite, go, adc_en, async_sel, reset_req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, startup_time_fuses;
  logic [3:0] clock_source_select_fuses;
  logic [5:0] src, gates;
  logic hreadyout, hresp, stall, wirq, wrst, adc_start, exec, ext_sel;
  logic [7:0] resumes, restarts;
  int errors, total_checks, cycles, adc_starts, n;
  smpc_row_s rows[5];
  logic [7:0] nops[4];
  smpc_sleep_ctrl #(.DLY_SHORT_CYC(DS), .DLY_LONG_CYC(DL)) DUT (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_clk_en(1'b1), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
    .i_clock_source_select_fuses(clock_source_select_fuses), .i_startup_time_fuses(startup_time_fuses), .i_sleep_exec(exec),
    .i_adc_enabled(adc_en), .i_timer2_async_select(async_sel), .o_cpu_stall(stall), .o_wake_irq(wirq),
    .o_wake_reset(wrst), .o_adc_start(adc_start), .i_irq_any(src[5]), .i_irq_adc(src[4]),
    .i_irq_level_ext(src[3]), .i_irq_twi_match(src[2]), .i_irq_timer2(src[1]), .i_irq_spm_ready(src[0]),
    .i_reset_req(reset_req), .o_clk_cpu_en(gates[5]), .o_clk_flash_en(gates[4]), .o_clk_io_en(gates[3]),
    .o_clk_adc_en(gates[2]), .o_clk_async_en(gates[1]), .o_osc_en(gates[0]), .o_ext_clk_sel(ext_sel));
  smpc_core_model core (.i_clock(i_clock), .i_nrst(i_nrst), .i_go(go), .i_cpu_stall(stall), .i_wake_irq(wirq),
    .i_wake_reset(wrst), .o_sleep_exec(exec), .o_resumes(resumes), .o_restarts(restarts));
  // ==========================================
  // Clock, timeout, helpers
  // Steady period: the clock never jumps in frequency
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cycles++;
    if (adc_start === 1'b1) adc_starts++;
    if (cycles == 4000) begin
      errors++;
      test_done();
    end
  end
  // Wide enough for the reset snapshot of status, gates and read data together
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge i_clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge i_clock);
    while (hreadyout !== 1'b1) @(posedge i_clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge i_clock);
    while (hreadyout !== 1'b1) @(posedge i_clock);
    r = hrdata;
    check(hresp, 0);
  endtask
  task automatic enter(input logic [7:0] c);
    bus(1'b1, 32'h0, {24'h0, c}, rd);
    @(posedge i_clock);
    go <= 1'b1;
    @(posedge i_clock);
    go <= 1'b0;
    repeat (4) @(posedge i_clock);
    #1;
  endtask
  // Edges from raising a source to the wake pulse
  task automatic wait_wake(input logic rst);
    n = 0;
    do begin
      @(posedge i_clock);
      #1;
      n++;
    end while ((rst ? wrst : wirq) !== 1'b1 && n < 60);
    @(posedge i_clock);
    src <= 6'h00;
    reset_req <= 1'b0;
    repeat (3) @(posedge i_clock);
    #1;
    check({stall, gates}, 7'h3F);
  endtask
  // ==========================================
  // Sequence
  initial begin
    {hsel, hwrite, go, adc_en, async_sel, reset_req, haddr, hwdata, htrans, startup_time_fuses, clock_source_select_fuses, src} = '0;
    {errors, total_checks, cycles, adc_starts} = '0;
    i_nrst = 1'b0;
    rows = '{'{3'h0, 4'h1, 1'b0, 1'b1, 6'h20, 6'h0F, 4'h1}, '{3'h1, 4'h1, 1'b0, 1'b1, 6'h10, 6'h07, 4'h1},
      '{3'h2, 4'h0, 1'b0, 1'b0, 6'h08, 6'h00, 4'h6}, '{3'h3, 4'h1, 1'b1, 1'b0, 6'h02, 6'h02, 4'h6},
      '{3'h6, 4'hA, 1'b0, 1'b0, 6'h04, 6'h01, 4'h6}};
    nops = '{8'h20, 8'hE0, 8'hC0, 8'hD0};
    repeat (2) @(posedge i_clock);
    #1;
    check({stall, gates, hreadyout, hrdata}, {8'h7F, 32'h0});
    i_nrst <= 1'b1;
    bus(1'b0, 32'h0, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b1, 32'h0, 32'hFFFF_FFFF, rd);
    bus(1'b0, 32'h0, 32'h0, rd);
    check(rd, 32'hFF);
    bus(1'b0, 32'hC, 32'h0, rd);
    check(rd, 32'h0);
    foreach (rows[i]) begin
      clock_source_select_fuses <= rows[i].ck;
      async_sel <= rows[i].as;
      adc_en <= rows[i].adc;
      enter({1'b1, rows[i].m, 4'h5});
      check(ext_sel, rows[i].ck == 4'h0);
      check({stall, gates}, {1'b1, rows[i].g});
      bus(1'b0, 32'h4, 32'h0, rd);
      check({rd[10:8], rd[2:0]}, {rows[i].m, 3'h1});
      src <= rows[i].s;
      wait_wake(1'b0);
      check(n, 7 + rows[i].st);
      bus(1'b0, 32'h0, 32'h0, rd);
      check(rd, {24'h0, 1'b1, rows[i].m, 4'h5});
    end
    check(adc_starts, 2);
    check(resumes, 5);
    clock_source_select_fuses <= 4'h0;
    foreach (nops[i]) begin
      enter(nops[i]);
      check({stall, gates}, 7'h3F);
    end
    for (int i = 0; i < 3; i++) begin
      startup_time_fuses <= (i == 0) ? 2'b01 : (i == 1) ? 2'b10 : 2'b00;
      enter(8'hA0);
      bus(1'b0, 32'h8, 32'h0, rd);
      check(rd[5:0], {startup_time_fuses, 4'h0});
      reset_req <= 1'b1;
      src <= 6'h08;
      wait_wake(1'b1);
      check(n, 3 + ((i == 0) ? DS : (i == 1) ? DL : 1));
      check({restarts, resumes}, {i[7:0] + 8'h01, 8'h05});
    end
    test_done();
  end
endmodule // tb_top
